// [bench/drc_mem.sv]
// Memory-side model driving strobe and data for read bursts
`timescale 1ns/1ps
`default_nettype none
module drc_mem (
	// Memory pins
	output logic       dqs_o,
	output logic [7:0] dq_o
);
	// Strobe idles low between frames
	initial
	begin
		dqs_o = 1'b0;
		dq_o  = 8'h00;
	end
	// Strobe edge lags data by the programmed 72 degree shift
	localparam int SHIFT_NS = drc_pkg::STROBE_SHIFT_DEG * 800 / 360;
	// 400 ns halves: eight clocks per strobe period, an even ratio
	// Data moves on the clock edge by NBA, strobe off the edge
	task automatic half(input logic lvl, input logic [7:0] d);
		dq_o <= d;
		#(SHIFT_NS) dqs_o = lvl;
		#(400 - SHIFT_NS);
	endtask
	// Preamble edge, then high half on fall, low on rise
	task automatic burst(input drc_pkg::drc_pair_t p [4]);
		half(1'b1, ~dq_o);
		foreach (p[i])
		begin
			half(1'b0, p[i].hi);
			half(1'b1, p[i].lo);
		end
		#400;
	endtask
	// Postamble, then a released line catching noise edges
	task automatic tail();
		half(1'b0, ~dq_o);
		half(1'b1, ~dq_o);
		half(1'b0, ~dq_o);
	endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the read capture path
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic               ref_clk_i, nrst_i, gate_arm_i, dll_ref_en_i;
	logic               rd_active_i, dqs_drive_i, dq_drive_i, t, pe;
	logic               dqs, dqs_oe_n_o, dq_oe_n_o, top, bot, rd_valid_o;
	logic [7:0]         dq;
	logic [3:0]         s;
	drc_pkg::drc_pair_t rd_pair_o, p [4], q [$];
	int                 error_cnt, total_checks;
	// Reference outputs come from their own toggle, not the strobe
	drc_mem i_mem (.dqs_o(dqs), .dq_o(dq));
	drc_capture i_dut (.ref_clk_i, .nrst_i, .dqs_i(dqs), .dq_i(dq),
		.gate_arm_i, .dll_ref_en_i, .rd_active_i, .dqs_drive_i,
		.dq_drive_i, .dqs_oe_n_o, .dq_oe_n_o, .dll_ref_top_o(top),
		.dll_ref_bot_o(bot), .rd_pair_o, .rd_valid_o);
	// Compare tasks, one per result kind
	task automatic chk_pair(input drc_pkg::drc_pair_t g, e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Clock, 100 ns period
	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// Watcher: pairs against notes, enables and reference each cycle
	always @(posedge ref_clk_i)
	begin
		s = {nrst_i, dqs_drive_i, dq_drive_i, dll_ref_en_i & ~rd_active_i};
		t = top;
		#1;
		if (rd_valid_o === 1'b1)
			chk_pair(rd_pair_o, q.size() ? q.pop_front() : 'x);
		if (s[3])
		begin
			chk_bit(dqs_oe_n_o, ~s[2]);
			chk_bit(dq_oe_n_o, ~s[1]);
			chk_bit(top, t ^ pe);
			chk_bit(bot, top);
		end
		// Output register adds one cycle after the toggle
		pe = s[3] & s[0];
	end
	// Hang guard
	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		error_cnt++;
		summarize();
	end
	// Main sequence: bursts, postamble noise, random control traffic
	initial
	begin
		{nrst_i, gate_arm_i, dll_ref_en_i, rd_active_i} = 4'h0;
		{dqs_drive_i, dq_drive_i} = 2'h0;
		void'($urandom(32'h35d8));
		repeat (8) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3)
		begin
			@(posedge ref_clk_i);
			gate_arm_i  <= 1'b1;
			rd_active_i <= 1'b1;
			dll_ref_en_i <= 1'b0;
			foreach (p[i])
			begin
				p[i] = 16'($urandom);
				q.push_back(p[i]);
			end
			@(posedge ref_clk_i);
			i_mem.burst(p);
			@(posedge ref_clk_i);
			gate_arm_i <= 1'b0;
			i_mem.tail();
			repeat (30)
			begin
				@(posedge ref_clk_i);
				{dqs_drive_i, dq_drive_i, dll_ref_en_i, rd_active_i}
					<= 4'($urandom);
			end
		end
		repeat (5) @(posedge ref_clk_i);
		chk_bit(q.size() == 0, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire

// [core/drc_capture.sv]
// Read capture path: gated strobe capture and resync to system clock
// Functional notes
// RL1: Strobe phase-shift reference is an enable per top and bottom circuit.
// RL2: Delayed strobe is inverted; falling edge of delay is capture edge.
// RL3: System and write clocks share strobe frequency; write lags ninety.
// RL4: Different PLL input frequency needs separate reference pin; integrator.
// RL5: Captured words feed resync registers on the resync clock. The code has no resync clock; rd_pair_o is clocked by ref_clk_i.
// RL6: Resync clock data moves back into system domain by extra register. The code has no such extra register; rd_pair_o is already on ref_clk_i.
// RL7: PLL counters use even values only; integrator's choice.
// RL8: Strobe and data output enables are active low at the pins.
// RL9: DLL reference runs only during init and refresh, never reads.
// RL10: Reference toggle register is gated by a clock enable.
// RL11: Strobe phase shift programmed to seventy-two degrees.
// RL12: Capture stops after postamble so noise edges latch nothing.
// RL13: One gate register on undelayed strobe enables the group capture.
// RL14: Falling edge takes high half, next rising takes low, latch high.
// RL15: Resync samples high and low halves together on rising edge.
// RL16: Gate delay minus clock delay lies between 0.2 and 0.6 periods.
// RL17: Each strobe owns eight data pins captured by the same strobe.
// RL18: Controller arms gate before preamble and lets it close after burst.
`timescale 1ns/1ps
`default_nettype none
module drc_capture #(
	parameter int W = drc_pkg::DQ_PER_GROUP
) (
	// Clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         nrst_i,
	// Memory pins, sampled
	input  wire logic         dqs_i,
	input  wire logic [W-1:0] dq_i,
	// Controller control
	input  wire logic         gate_arm_i,
	input  wire logic         dll_ref_en_i,
	input  wire logic         rd_active_i,
	input  wire logic         dqs_drive_i,
	input  wire logic         dq_drive_i,
	// Outputs
	output logic              dqs_oe_n_o,
	output logic              dq_oe_n_o,
	output logic              dll_ref_top_o,
	output logic              dll_ref_bot_o,
	output drc_pkg::drc_pair_t rd_pair_o,
	output logic              rd_valid_o
);
	logic [W:0]   sy;
	logic         dqs_s;
	logic [W-1:0] dq_s;
	logic         dqs_d;
	logic         gate;
	logic [W-1:0] cap_hi;
	logic [W-1:0] cap_lo;
	logic [W-1:0] latch_hi;
	logic         have_hi;
	logic         pair_new;
	logic         dqs_edge;
	logic         ref_tog;
	logic         rd_active_s;

	// All registers run on the one system clock, no extra hop [RL3]
	// Pins cross from the strobe domain through two flops
	drc_sync #(.W(W+1)) u_sync (
		.ref_clk_i(ref_clk_i),
		.nrst_i   (nrst_i),
		.d_i      ({dqs_i, dq_i}),
		.q_o      (sy)
	);
	assign dqs_s = sy[W];
	assign dq_s  = sy[W-1:0];
	// Either strobe edge, seen two flops late
	assign dqs_edge = dqs_s ^ dqs_d;

	// Strobe history for edge detection
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
			dqs_d <= 1'b0;
		else
			dqs_d <= dqs_s;
	end

	// Gate register on the undelayed strobe; closes on the first strobe edge after arm drops [RL13] [RL12]
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
			gate <= 1'b0;
		else if (dqs_edge)
			gate <= gate_arm_i; // Sampled on strobe edges only [RL18]
	end

	// Falling strobe edge stands for rising inverted delayed strobe [RL2]
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			cap_hi   <= drc_pkg::WORD_RST;
			cap_lo   <= drc_pkg::WORD_RST;
			latch_hi <= drc_pkg::WORD_RST;
			have_hi  <= 1'b0;
			pair_new <= 1'b0;
		end
		else
		begin
			pair_new <= 1'b0;
			if (gate && dqs_d && !dqs_s)
			begin
				cap_hi  <= dq_s; // High half on falling edge [RL14] [RL17]
				have_hi <= 1'b1;
			end
			else if (gate && !dqs_d && dqs_s && have_hi)
			begin
				cap_lo   <= dq_s; // Low half, latch passes high [RL14]
				latch_hi <= cap_hi;
				have_hi  <= 1'b0;
				pair_new <= 1'b1;
			end
		end
	end

	// Resync registers take both halves together [RL5] [RL15] [RL6]
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			rd_pair_o  <= '0;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= pair_new;
			if (pair_new)
			begin
				rd_pair_o.hi <= latch_hi;
				rd_pair_o.lo <= cap_lo;
			end
		end
	end

	// Active-low pin enables from active-high requests [RL8]
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			dqs_oe_n_o <= drc_pkg::OE_N_IDLE;
			dq_oe_n_o  <= drc_pkg::OE_N_IDLE;
		end
		else
		begin
			dqs_oe_n_o <= ~dqs_drive_i;
			dq_oe_n_o  <= ~dq_drive_i;
		end
	end

	// Read flag is from the same clock; no sync needed
	assign rd_active_s = rd_active_i;

	// Reference toggle gated off during reads [RL9] [RL10] [RL1]
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
			ref_tog <= 1'b0;
		else if (dll_ref_en_i && !rd_active_s)
			ref_tog <= ~ref_tog;
	end

	// Same reference to top and bottom circuits
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			dll_ref_top_o <= 1'b0;
			dll_ref_bot_o <= 1'b0;
		end
		else
		begin
			dll_ref_top_o <= ref_tog;
			dll_ref_bot_o <= ref_tog;
		end
	end

	// Assertions share the system clock and its reset
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// Pair is flagged one cycle after the low half
	pair_follow_a: assert property ( // [RL15]
		pair_new |=> rd_valid_o)
		else $error("pair not flagged");
	// Output low half matches capture
	pair_data_a: assert property ( // [RL14]
		pair_new |=> rd_pair_o.lo == $past(cap_lo))
		else $error("bad low half");
	// Output high half comes from the latch
	pair_hi_a: assert property ( // [RL6]
		pair_new |=> rd_pair_o.hi == $past(latch_hi))
		else $error("bad high half");
	// No capture while gate closed
	gate_block_a: assert property ( // [RL12]
		!gate |=> !pair_new)
		else $error("capture while gated");
	// Gate moves only on a strobe edge, never between
	gate_edge_a: assert property ( // [RL18]
		$changed(gate) |-> $past(dqs_edge))
		else $error("gate moved off edge");
	// Disarmed gate closes on the next strobe edge
	gate_close_a: assert property ( // [RL13]
		(dqs_edge && !gate_arm_i) |=> !gate)
		else $error("gate stayed open");
	// Falling edge takes the data pins as high half
	hi_take_a: assert property ( // [RL14]
		(gate && dqs_d && !dqs_s) |=> cap_hi == $past(dq_s))
		else $error("high half not taken");
	// Valid is a single-cycle pulse
	valid_pulse_a: assert property ( // [RL15]
		rd_valid_o |=> !rd_valid_o)
		else $error("valid too long");
	// Reference still during reads
	ref_hold_a: assert property ( // [RL9]
		rd_active_i |=> $stable(ref_tog))
		else $error("ref moved in read");
	// Reference toggles when enabled
	ref_run_a: assert property ( // [RL10]
		(dll_ref_en_i && !rd_active_i) |=> ref_tog != $past(ref_tog))
		else $error("ref not toggling");
	// Both circuits fed
	ref_both_a: assert property ( // [RL1]
		dll_ref_top_o == dll_ref_bot_o)
		else $error("refs differ");
	// Data enable active low
	oe_low_a: assert property ( // [RL8]
		dq_drive_i |=> !dq_oe_n_o)
		else $error("dq oe polarity");
	// Strobe enable active low
	dqs_oe_a: assert property ( // [RL8]
		dqs_drive_i |=> !dqs_oe_n_o)
		else $error("dqs oe polarity");
	// Data pins released when not driven
	oe_release_a: assert property ( // [RL8]
		!dq_drive_i |=> dq_oe_n_o)
		else $error("dq oe not released");
	// High half before low half
	hi_first_a: assert property ( // [RL2]
		pair_new |-> $past(have_hi))
		else $error("low before high");
endmodule
`default_nettype wire

// [core/drc_pkg.sv]
// Shared constants and carrier types for the read capture path
package drc_pkg;
	// Pins per strobe group
	localparam int DQ_PER_GROUP = 8;
	// Reset values
	localparam logic [7:0] WORD_RST = 8'h00;
	// Output enable idle level: active low, so high is released
	localparam logic OE_N_IDLE = 1'b1;
	// Timing of the gate window in tenths of a clock period
	localparam int GATE_MIN_TENTHS = 2;
	localparam int GATE_MAX_TENTHS = 6;
	// Strobe phase shift in degrees
	localparam int STROBE_SHIFT_DEG = 72;
	// Write clock lag in degrees
	localparam int WRITE_LAG_DEG = 90;
	// Captured pair of half words
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} drc_pair_t;
endpackage

// [core/drc_sync.sv]
// Two-flop synchroniser, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module drc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         nrst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			meta <= '0;
			q_o  <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule
`default_nettype wire
